//--- pkg/lcd_ctl_pkg.sv
// Shared constants and types for the character LCD instruction decoder
package lcd_ctl_pkg;
  // Host register select codes {high, low}
  localparam logic [1:0] SEL_DATA = 2'b11;
  localparam logic [1:0] SEL_INSTR = 2'b10;
  localparam logic [1:0] SEL_EXPAN = 2'b00;
  // Timing: oscillator-referenced execution time scaled to sys_clk
  localparam int CLK_HZ = 40000000;
  localparam int EXEC_NS = 37000;
  localparam int EXEC_CYC = (EXEC_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int STAT_NS = 1000;
  localparam int STAT_CYC = (STAT_NS * (CLK_HZ / 1000000)) / 1000;
  // Frame periods in ns for 75.0, 56.3 and 79.4 Hz
  localparam int FRAME9_NS = 13333333;
  localparam int FRAME12_NS = 17761989;
  localparam int FRAME17_NS = 12594458;
  localparam int FRAME9_CYC = FRAME9_NS / 25;
  localparam int FRAME12_CYC = FRAME12_NS / 25;
  localparam int FRAME17_CYC = FRAME17_NS / 25;
  // Common counts per duty
  localparam logic [4:0] COMS_9 = 5'h09;
  localparam logic [4:0] COMS_12 = 5'h0C;
  localparam logic [4:0] COMS_17 = 5'h11;
  // Reset values
  localparam logic [4:0] CONTRAST_RST = 5'h00;
  localparam logic [6:0] ADDR_RST = 7'h00;
  // RAM depths
  localparam int DISP_DEPTH = 128;
  localparam int PAT_DEPTH = 64;
  localparam int MARK_DEPTH = 32;
  typedef enum logic [1:0] {TGT_DISP, TGT_PAT, TGT_MARK} ram_tgt_t;
endpackage

//--- verilog/data_fifo.sv
// Small synchronous FIFO with valid/ready handshakes
`timescale 1ns/1ps
module data_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // Handshake terms; full and empty come straight from the count
  assign in_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count next values
  always_comb
  begin
    wp_nxt = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop)
      cnt_nxt = cnt_r + 1'b1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 1'b1;
  end

  // Storage only changes on a push, so it needs no reset
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push)
      mem_r[wp_r] <= in_data;
  end
endmodule

//--- verilog/frame_timer.sv
// Frame period and common scan counter for the selected duty
`timescale 1ns/1ps
module frame_timer
  import lcd_ctl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Scan format
  input wire logic [4:0] com_count,
  input wire logic [23:0] frame_cycles,
  // Scan position
  output logic [4:0] scan_step,
  output logic frame_tick
);
  logic [23:0] slot_len;
  logic [23:0] tick_r, tick_nxt;
  logic [4:0] step_r, step_nxt;
  logic tickp_r, tickp_nxt;

  // One step per common; frame period split evenly across commons
  assign slot_len = frame_cycles / {19'h0, com_count};
  assign scan_step = step_r;
  assign frame_tick = tickp_r;

  always_comb
  begin
    tick_nxt = tick_r + 24'h1;
    step_nxt = step_r;
    tickp_nxt = 1'b0;
    if (tick_r + 24'h1 >= slot_len)
    begin
      tick_nxt = 24'h0;
      if (step_r + 5'h1 >= com_count)
      begin
        step_nxt = 5'h0;
        tickp_nxt = 1'b1;
      end
      else
        step_nxt = step_r + 5'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      tick_r <= 24'h0;
      step_r <= 5'h0;
      tickp_r <= 1'b0;
    end
    else
    begin
      tick_r <= tick_nxt;
      step_r <= step_nxt;
      tickp_r <= tickp_nxt;
    end
  end
endmodule

//--- verilog/char_lcd_instruction_decoder.sv
// Instruction decoder of a character LCD controller: RAMs, address counter, busy, scan
// Contract
// - Line and font bits pick 1/9, 1/12 or 1/17 duty with 9, 12, 17 commons.
// - Instruction 01xxxxxx loads a pattern RAM address and targets pattern RAM.
// - Instruction 1xxxxxxx loads a display RAM address and targets display RAM.
// - One address counter; target RAM held until next address-setting instruction.
// - Data write stores the bus byte at the counter in the selected RAM.
// - Status read returns busy on bit 7 and counter on bits 6..0 within 1 us.
// - While busy, data and expansion reads are refused and writes wait in the queue; the status read still answers.
// - Counter read back while busy may be off by one.
// - Data read returns the byte at the counter, then steps the counter.
// - Address, data, function and contrast instructions stay busy up to 37 us.
// - Expansion 0000001x latches marker line select; normal scan order mapping.
// - Reversed scan order maps marker select to the reversed common order.
// - Expansion 001xxxxx stores five bits into the contrast register.
// - Expansion read returns 000 then the five contrast bits.
// - Expansion 011xxxxx loads a marker RAM address and targets marker RAM.
// - Frame rate is 75.0, 56.3 or 79.4 Hz for the three duties.
// - Commons beyond the active duty drive the display-off waveform.
// - Each RAM access steps the counter up if entry bit is 1, else down.
// - Line bit 1 selects two lines; font bit picks small or large font.
`timescale 1ns/1ps
module char_lcd_instruction_decoder
  import lcd_ctl_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int EXEC_COUNT = EXEC_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Host access strobe and selects (pins, asynchronous)
  input wire logic host_strobe,
  input wire logic register_select_high,
  input wire logic register_select_low,
  input wire logic read_not_write,
  input wire logic [7:0] bus_in,
  // Host read data
  output logic [7:0] bus_out,
  output logic bus_oe,
  // Strap pin for common scan order
  input wire logic common_scan_reverse,
  // Display state
  output logic [4:0] contrast_level,
  output logic marker_line_select,
  output logic two_line_mode,
  output logic large_font,
  output logic [4:0] active_commons,
  output logic [16:0] backplane_line,
  output logic [16:0] backplane_off,
  output logic busy_indicator
);
  // Pin synchronisers: first stage read only by the second
  logic [12:0] s1_r, s2_r;
  logic stb_d_r;
  logic csr_r;
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      s1_r <= 13'h0000;
      s2_r <= 13'h0000;
      stb_d_r <= 1'b0;
      csr_r <= 1'b0;
    end
    else
    begin
      // Bit 12 scan order, 11 strobe, 10:9 selects, 8 direction, 7:0 data
      s1_r <= {common_scan_reverse, host_strobe, register_select_high,
               register_select_low, read_not_write, bus_in};
      s2_r <= s1_r;
      stb_d_r <= s2_r[11];
      csr_r <= s2_r[12];
    end
  end

  // Decoded access; taken on the rising edge of the synchronised strobe
  logic acc;
  logic [1:0] sel;
  logic rd;
  logic [7:0] din;
  assign acc = s2_r[11] && !stb_d_r;
  assign sel = s2_r[10:9];
  assign rd = s2_r[8];
  assign din = s2_r[7:0];

  // Writes are queued so that a burst meeting a busy core is not lost
  logic wq_valid, wq_ready, wq_in_ready;
  logic [9:0] wq_data;
  data_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_wq (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(acc && !rd),
    .in_ready(wq_in_ready),
    .in_data({sel, din}),
    .out_valid(wq_valid),
    .out_ready(wq_ready),
    .out_data(wq_data)
  );

  // Core state
  logic [7:0] disp_r [DISP_DEPTH];
  logic [7:0] pat_r [PAT_DEPTH];
  logic [7:0] mark_r [MARK_DEPTH];
  ram_tgt_t tgt_r, tgt_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic entry_up_r, entry_up_nxt;
  logic two_r, two_nxt, font_r, font_nxt;
  logic [4:0] con_r, con_nxt;
  logic mark_sel_r, mark_sel_nxt;
  logic [15:0] busy_cnt_r, busy_cnt_nxt;
  logic busy_r, busy_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic oe_r, oe_nxt;
  logic [7:0] stat_cnt_r, stat_cnt_nxt;
  logic wr_en;
  logic [7:0] ram_q;

  // Current RAM content at the counter for the selected target
  always_comb
  begin
    case (tgt_r)
      TGT_PAT: ram_q = pat_r[addr_r[5:0]];
      TGT_MARK: ram_q = mark_r[addr_r[4:0]];
      default: ram_q = disp_r[addr_r];
    endcase
  end

  // Write commands pop only when idle; a busy core stalls the queue
  // A read taken in the same cycle owns the core, so the queue head must wait
  assign wq_ready = (busy_cnt_r == 16'h0) && !(acc && rd);

  // Instruction execution, status and data reads
  always_comb
  begin
    logic [1:0] wsel;
    logic [7:0] wd;
    logic start;
    wsel = wq_data[9:8];
    wd = wq_data[7:0];
    start = 1'b0;
    tgt_nxt = tgt_r;
    addr_nxt = addr_r;
    entry_up_nxt = entry_up_r;
    two_nxt = two_r;
    font_nxt = font_r;
    con_nxt = con_r;
    mark_sel_nxt = mark_sel_r;
    rdata_nxt = rdata_r;
    oe_nxt = oe_r;
    stat_cnt_nxt = (stat_cnt_r != 8'h0) ? stat_cnt_r - 8'h1 : 8'h0;
    wr_en = 1'b0;
    if (stat_cnt_r == 8'h1)
      oe_nxt = 1'b0;
    // Reads are answered at once; only the status read is allowed while busy
    if (acc && rd)
    begin
      if (sel == SEL_INSTR)
      begin
        rdata_nxt = {busy_cnt_r != 16'h0, addr_r};
        oe_nxt = 1'b1;
        stat_cnt_nxt = 8'(STAT_CYC);
      end
      else if (busy_cnt_r == 16'h0)
      begin
        oe_nxt = 1'b1;
        stat_cnt_nxt = 8'(STAT_CYC);
        start = 1'b1;
        if (sel == SEL_DATA)
        begin
          rdata_nxt = ram_q;
          addr_nxt = entry_up_r ? addr_r + 7'h1 : addr_r - 7'h1;
        end
        else
          rdata_nxt = {3'b000, con_r};
      end
    end
    else if (wq_valid && wq_ready)
    begin
      start = 1'b1;
      if (wsel == SEL_DATA)
      begin
        wr_en = 1'b1;
        addr_nxt = entry_up_r ? addr_r + 7'h1 : addr_r - 7'h1;
      end
      else if (wsel == SEL_INSTR)
      begin
        if (wd[7])
        begin
          addr_nxt = wd[6:0];
          tgt_nxt = TGT_DISP;
        end
        else if (wd[6])
        begin
          addr_nxt = {1'b0, wd[5:0]};
          tgt_nxt = TGT_PAT;
        end
        else if (wd[5])
        begin
          two_nxt = wd[3];
          font_nxt = wd[2];
        end
        else if (wd[2] && !wd[3] && !wd[4])
          entry_up_nxt = wd[1];
        else if (wd[4] && !wd[3])
          addr_nxt = wd[2] ? addr_r + 7'h1 : addr_r - 7'h1;
      end
      else if (wsel == SEL_EXPAN)
      begin
        if (wd[7:5] == 3'b011)
        begin
          addr_nxt = {2'b00, wd[4:0]};
          tgt_nxt = TGT_MARK;
        end
        else if (wd[7:5] == 3'b001)
          con_nxt = wd[4:0];
        else if (wd[7:1] == 7'h01)
          mark_sel_nxt = wd[0];
      end
    end
    busy_cnt_nxt = start ? 16'(EXEC_COUNT) :
                   (busy_cnt_r != 16'h0) ? busy_cnt_r - 16'h1 : 16'h0;
    busy_nxt = (busy_cnt_nxt != 16'h0);
  end

  // Registers of the core
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      tgt_r <= TGT_DISP;
      addr_r <= ADDR_RST;
      entry_up_r <= 1'b1;
      two_r <= 1'b0;
      font_r <= 1'b0;
      con_r <= CONTRAST_RST;
      mark_sel_r <= 1'b0;
      busy_cnt_r <= 16'h0;
      busy_r <= 1'b0;
      rdata_r <= 8'h00;
      oe_r <= 1'b0;
      stat_cnt_r <= 8'h00;
    end
    else
    begin
      tgt_r <= tgt_nxt;
      addr_r <= addr_nxt;
      entry_up_r <= entry_up_nxt;
      two_r <= two_nxt;
      font_r <= font_nxt;
      con_r <= con_nxt;
      mark_sel_r <= mark_sel_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      busy_r <= busy_nxt;
      rdata_r <= rdata_nxt;
      oe_r <= oe_nxt;
      stat_cnt_r <= stat_cnt_nxt;
    end
    // RAM contents are undefined after reset, as on the real part
    if (wr_en)
    begin
      case (tgt_r)
        TGT_PAT: pat_r[addr_r[5:0]] <= wq_data[7:0];
        TGT_MARK: mark_r[addr_r[4:0]] <= wq_data[7:0];
        default: disp_r[addr_r] <= wq_data[7:0];
      endcase
    end
  end

  // Scan format from line and font bits
  logic [4:0] coms;
  logic [23:0] frame_len;
  always_comb
  begin
    if (two_r)
    begin
      coms = COMS_17;
      frame_len = 24'(FRAME17_CYC);
    end
    else if (font_r)
    begin
      coms = COMS_12;
      frame_len = 24'(FRAME12_CYC);
    end
    else
    begin
      coms = COMS_9;
      frame_len = 24'(FRAME9_CYC);
    end
  end

  logic [4:0] step;
  frame_timer u_ft (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .com_count(coms),
    .frame_cycles(frame_len),
    .scan_step(step),
    .frame_tick()
  );

  // Map scan step to a physical common, honouring marker select and direction
  logic [4:0] base, phys;
  logic [16:0] line_nxt, off_nxt;
  always_comb
  begin
    if (mark_sel_r)
      base = (step + 5'h1 >= coms) ? 5'h0 : step + 5'h1;
    else
      base = step;
    phys = csr_r ? coms - 5'h1 - base : base;
    line_nxt = 17'h0;
    off_nxt = 17'h0;
    for (int i = 0; i < 17; i++)
    begin
      line_nxt[i] = (5'(i) == phys);
      off_nxt[i] = (5'(i) >= coms);
    end
  end

  // Output registers
  logic [16:0] line_r, off_r;
  logic [4:0] coms_r;
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      line_r <= 17'h0;
      off_r <= 17'h1FFFF << COMS_9; // Matches the reset duty, so nothing flips on release
      coms_r <= COMS_9;
    end
    else
    begin
      line_r <= line_nxt;
      off_r <= off_nxt;
      coms_r <= coms;
    end
  end

  assign bus_out = rdata_r;
  assign bus_oe = oe_r;
  assign contrast_level = con_r;
  assign marker_line_select = mark_sel_r;
  assign two_line_mode = two_r;
  assign large_font = font_r;
  assign active_commons = coms_r;
  assign backplane_line = line_r;
  assign backplane_off = off_r;
  assign busy_indicator = busy_r;

  // Checks
  property p_busy_len;
    @(posedge sys_clk) disable iff (!resetn)
    $rose(busy_cnt_r != 16'h0) |-> (busy_cnt_r != 16'h0) [*8];
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy too short");
  property p_no_pop_busy;
    @(posedge sys_clk) disable iff (!resetn)
    (busy_cnt_r != 16'h0) |-> !wr_en ##1 $stable(con_r);
  endproperty
  a_no_pop_busy: assert property (p_no_pop_busy) else $error("write while busy");
  property p_stat;
    @(posedge sys_clk) disable iff (!resetn)
    (acc && rd && sel == SEL_INSTR) |=> oe_r && rdata_r[6:0] == $past(addr_r);
  endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
  property p_con;
    @(posedge sys_clk) disable iff (!resetn)
    (wq_valid && wq_ready && wq_data[9:5] == 5'b00001) |=> con_r == $past(wq_data[4:0]);
  endproperty
  a_con: assert property (p_con) else $error("contrast not stored");
  property p_disp;
    @(posedge sys_clk) disable iff (!resetn)
    (wq_valid && wq_ready && wq_data[9:7] == 3'b101) |=> tgt_r == TGT_DISP;
  endproperty
  a_disp: assert property (p_disp) else $error("display target");
  property p_pat;
    @(posedge sys_clk) disable iff (!resetn)
    (wq_valid && wq_ready && wq_data[9:6] == 4'b1001) |=> tgt_r == TGT_PAT;
  endproperty
  a_pat: assert property (p_pat) else $error("pattern target");
  property p_step;
    @(posedge sys_clk) disable iff (!resetn)
    wr_en |=> addr_r == ($past(entry_up_r) ? $past(addr_r) + 7'h1 : $past(addr_r) - 7'h1);
  endproperty
  a_step: assert property (p_step) else $error("counter step");
  property p_duty;
    @(posedge sys_clk) disable iff (!resetn)
    coms == (two_r ? COMS_17 : font_r ? COMS_12 : COMS_9);
  endproperty
  a_duty: assert property (p_duty) else $error("duty");
  property p_off;
    @(posedge sys_clk) disable iff (!resetn)
    !two_r && !font_r && $stable(two_r) && $stable(font_r) |=> off_r[16:9] == 8'hFF;
  endproperty
  a_off: assert property (p_off) else $error("off commons");
endmodule

//--- tb/host_cpu_model.sv
// Host microcontroller model driving the parallel access pins
`timescale 1ns/1ps
module host_cpu_model (
  // Clock
  input wire logic sys_clk,
  // Access pins toward the controller
  output logic host_strobe,
  output logic rs_high,
  output logic rs_low,
  output logic rnw,
  output logic [7:0] bus_in,
  // Read data from the controller
  input wire logic [7:0] bus_out,
  input wire logic bus_oe
);
  // Released pins sit at their pull-up level
  initial
  begin
    host_strobe = 1'b0;
    {rs_high, rs_low, rnw} = 3'b111;
    bus_in = 8'hFF;
  end

  // One raw access; selects and data stay put while the strobe is high
  task automatic xfer(input logic [1:0] sel, input logic rd, input logic [7:0] wd,
    output logic [7:0] rdat, output logic got);
    begin
      rdat = 8'h00;
      got = 1'b0;
      @(posedge sys_clk);
      {rs_high, rs_low} <= sel;
      rnw <= rd;
      bus_in <= rd ? 8'hFF : wd;
      @(posedge sys_clk);
      host_strobe <= 1'b1;
      repeat (8)
      begin
        @(posedge sys_clk);
        if (bus_oe === 1'b1 && got === 1'b0)
        begin
          rdat = bus_out;
          got = 1'b1;
        end
      end
      host_strobe <= 1'b0;
      @(posedge sys_clk);
      {rs_high, rs_low, rnw} <= 3'b111;
      bus_in <= 8'hFF;
      // Let the read answer lapse so two answers never overlap
      for (int i = 0; i < 60 && bus_oe === 1'b1; i++)
        @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
    end
  endtask

  // Polite access: poll status until idle before anything else
  task automatic op(input logic [1:0] sel, input logic rd, input logic [7:0] wd,
    output logic [7:0] rdat, output logic got);
    logic [7:0] st;
    logic g;
    begin
      st = 8'h80;
      for (int i = 0; i < 100 && st[7] !== 1'b0; i++)
        xfer(2'b10, 1'b1, 8'h00, st, g);
      xfer(sel, rd, wd, rdat, got);
    end
  endtask
endmodule

//--- tb/char_lcd_instruction_decoder_tb.sv
// Self-checking bench for the character LCD instruction decoder
`timescale 1ns/1ps
module char_lcd_instruction_decoder_tb;
  import lcd_ctl_pkg::*;
  // Shortened execution time keeps the run brief
  localparam int EXEC_SHORT = 100;
  logic sys_clk, resetn, host_strobe, rs_high, rs_low, rnw, common_scan_reverse;
  logic [7:0] bus_in, bus_out, rd;
  logic bus_oe, marker_line_select, two_line_mode, large_font, busy_indicator, got;
  logic [4:0] contrast_level, active_commons;
  logic [16:0] backplane_line, backplane_off;
  int num_errors, comparisons, cycles;
  logic [4:0] ac_tab [4] = '{COMS_9, COMS_12, COMS_17, COMS_17};
  logic [16:0] off_tab [4] = '{17'h1FE00, 17'h1F000, 17'h00000, 17'h00000};
  logic [4:0] ct_tab [3] = '{5'h1F, 5'h00, 5'h15};
  // First common of each frame; the scan stays on its first step for the whole run
  logic [16:0] ln_tab [4] = '{17'h00001, 17'h00800, 17'h00001, 17'h10000};

  char_lcd_instruction_decoder #(.FIFO_DEPTH(8), .EXEC_COUNT(EXEC_SHORT)) DUT (
    .sys_clk(sys_clk), .resetn(resetn), .host_strobe(host_strobe),
    .register_select_high(rs_high), .register_select_low(rs_low),
    .read_not_write(rnw), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .common_scan_reverse(common_scan_reverse), .contrast_level(contrast_level),
    .marker_line_select(marker_line_select), .two_line_mode(two_line_mode),
    .large_font(large_font), .active_commons(active_commons),
    .backplane_line(backplane_line), .backplane_off(backplane_off),
    .busy_indicator(busy_indicator));

  host_cpu_model u_host (
    .sys_clk(sys_clk), .host_strobe(host_strobe), .rs_high(rs_high), .rs_low(rs_low),
    .rnw(rnw), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe));

  // 40 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Hang guard, well above the expected run length
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    begin
      comparisons++;
      if (seen !== exp)
      begin
        num_errors++;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    u_host.op(sel, 1'b0, d, rd, got);
  endtask

  task automatic rdc(input logic [1:0] sel, input logic [7:0] exp);
    begin
      u_host.op(sel, 1'b1, 8'h00, rd, got);
      check({8'h00, got, rd}, {8'h01, exp});
    end
  endtask

  // Wait for idle, then step off the edge before looking at outputs
  task automatic settle();
    begin
      u_host.op(SEL_INSTR, 1'b1, 8'h00, rd, got);
      @(negedge sys_clk);
    end
  endtask

  task automatic end_of_test();
    begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  initial
  begin
    resetn = 1'b0;
    common_scan_reverse = 1'b0;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    settle();
    check(contrast_level, CONTRAST_RST);
    check(busy_indicator, 1'b0);
    check(active_commons, COMS_9);
    rdc(SEL_INSTR, 8'h00);
    // Every line/font code, with scan order flipped on alternate passes
    for (int k = 0; k < 4; k++)
    begin
      common_scan_reverse <= k[0];
      wr(SEL_INSTR, 8'h30 | {4'h0, k[1:0], 2'b00});
      settle();
      check(two_line_mode, k[1]);
      if (!k[1]) check(large_font, k[0]);
      check(active_commons, ac_tab[k]);
      check(backplane_off, off_tab[k]);
      check(backplane_line & backplane_off, 17'h00000);
      check(backplane_line, ln_tab[k]);
      check(17'($countones(backplane_line)), 17'h00001);
    end
    // Busy window: expansion read refused, status still answers
    wr(SEL_INSTR, 8'h06);
    wr(SEL_INSTR, 8'hC0);
    u_host.xfer(SEL_EXPAN, 1'b1, 8'h00, rd, got);
    check(got, 1'b0);
    u_host.xfer(SEL_INSTR, 1'b1, 8'h00, rd, got);
    check({got, rd[7]}, 2'b11);
    for (int i = 0; i < EXEC_SHORT && busy_indicator === 1'b1; i++)
      @(posedge sys_clk);
    #1;
    check(busy_indicator, 1'b0);
    rdc(SEL_INSTR, 8'h40);
    // Display RAM write, read back, both step directions
    wr(SEL_DATA, 8'h5A);
    wr(SEL_DATA, 8'hA5);
    rdc(SEL_INSTR, 8'h42);
    wr(SEL_INSTR, 8'hC0);
    rdc(SEL_DATA, 8'h5A);
    rdc(SEL_DATA, 8'hA5);
    rdc(SEL_INSTR, 8'h42);
    wr(SEL_INSTR, 8'h04);
    wr(SEL_INSTR, 8'hC1);
    rdc(SEL_DATA, 8'hA5);
    rdc(SEL_INSTR, 8'h40);
    wr(SEL_INSTR, 8'h06);
    // Pattern RAM kept apart from display RAM
    wr(SEL_INSTR, 8'h45);
    rdc(SEL_INSTR, 8'h05);
    wr(SEL_DATA, 8'h11);
    wr(SEL_INSTR, 8'h45);
    rdc(SEL_DATA, 8'h11);
    wr(SEL_INSTR, 8'hC0);
    rdc(SEL_DATA, 8'h5A);
    // Marker RAM write and read back at address 0x13 of its 32 entries
    wr(SEL_EXPAN, 8'h73);
    rdc(SEL_INSTR, 8'h13);
    wr(SEL_DATA, 8'h77);
    wr(SEL_EXPAN, 8'h73);
    rdc(SEL_DATA, 8'h77);
    rdc(SEL_INSTR, 8'h14);
    // Contrast boundaries and a middle value
    for (int c = 0; c < 3; c++)
    begin
      wr(SEL_EXPAN, {3'b001, ct_tab[c]});
      rdc(SEL_EXPAN, {3'b000, ct_tab[c]});
      settle();
      check(contrast_level, ct_tab[c]);
    end
    // Marker line select set then cleared
    for (int m = 1; m >= 0; m--)
    begin
      wr(SEL_EXPAN, {7'b0000001, m[0]});
      settle();
      check(marker_line_select, m[0]);
      check(backplane_line, m[0] ? 17'h08000 : 17'h10000);
    end
    end_of_test();
  end
endmodule
